// File: decode_user_ctrl.sv
/*
 * user logic that drives the carry-select chain, the one-hot decoder used as a
 * demultiplexer and a two-stage cascadable wide AND used as a pattern matcher.
 * assumes the decoding elements are combinational and that their outputs are
 * settled within one clock period of the registered inputs.
 */
`timescale 1ns/1ps

module decode_user_ctrl (
	input  wire logic                              core_clk_i,
	input  wire logic                              reset_i,
	input  wire logic [decode_user_pkg::ADD_W-1:0]   add_a_i,
	input  wire logic [decode_user_pkg::ADD_W-1:0]   add_b_i,
	input  wire logic                              add_cin_i,
	input  wire logic                              demux_data_i,
	input  wire logic [decode_user_pkg::ADDR_W-1:0]  demux_addr_i,
	input  wire logic [decode_user_pkg::MATCH_W-1:0] match_word_i,
	input  wire logic [decode_user_pkg::MATCH_W-1:0] match_pattern_i,
	input  wire logic                              chain_carry_out_i,
	input  wire logic [decode_user_pkg::LINE_N-1:0]  demux_lines_i,
	input  wire logic                              match_hit_i,
	output logic      [decode_user_pkg::ADD_W-1:0]   direct_in_o,
	output logic      [decode_user_pkg::ADD_W-1:0]   select_o,
	output logic                                   init_direct_in_o,
	output logic                                   gate_enable_o,
	output logic      [decode_user_pkg::ADDR_W-1:0]  address_o,
	output logic      [decode_user_pkg::HALF_W-1:0]  decode_low_o,
	output logic      [decode_user_pkg::HALF_W-1:0]  decode_high_o,
	output logic                                   cascade_init_o,
	output logic                                   carry_o,
	output logic      [decode_user_pkg::LINE_N-1:0]  demux_capture_o,
	output logic                                   match_o
);
	import decode_user_pkg::*;

	encode_link_if link ();

	input_encoder u_encoder (
		.link (link.encoder)
	);

	assign link.opnd_a  = add_a_i;
	assign link.opnd_b  = add_b_i;
	assign link.word    = match_word_i;
	assign link.pattern = match_pattern_i;

	wire logic [HALF_W-1:0] next_decode_low;
	wire logic [HALF_W-1:0] next_decode_high;

	assign next_decode_low  = link.decode_in[HALF_W-1:0];
	assign next_decode_high = link.decode_in[MATCH_W-1:HALF_W];

	// adder stages: operand a on the direct inputs, xor on the selects
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			direct_in_o      <= NIBBLE_RESET;
			select_o         <= NIBBLE_RESET;
			init_direct_in_o <= BIT_RESET;
		end else begin
			direct_in_o      <= add_a_i;
			select_o         <= link.select;
			init_direct_in_o <= add_cin_i;
		end
	end

	// demux: the data bit rides on the gate enable, never on the address
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			gate_enable_o <= BIT_RESET;
			address_o     <= NIBBLE_RESET;
		end else begin
			gate_enable_o <= demux_data_i;
			address_o     <= demux_addr_i;
		end
	end

	// pattern matcher inputs; the second stage's cascade is wired from the
	// first stage's output outside, so only the init stage is driven here
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			decode_low_o   <= HALF_RESET;
			decode_high_o  <= HALF_RESET;
			cascade_init_o <= BIT_RESET;
		end else begin
			decode_low_o   <= next_decode_low;
			decode_high_o  <= next_decode_high;
			cascade_init_o <= CASCADE_INIT_ON;
		end
	end

	// results sampled one cycle after the inputs were launched; registering
	// them costs a cycle of latency but keeps the outside path to one period
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			carry_o         <= BIT_RESET;
			demux_capture_o <= LINE_RESET;
			match_o         <= BIT_RESET;
		end else begin
			carry_o         <= chain_carry_out_i;
			demux_capture_o <= demux_lines_i;
			match_o         <= match_hit_i;
		end
	end

	// reset is sampled high on the edge that releases it, so that edge starts no check
	sequence s_data_high;
		!reset_i && demux_data_i;
	endsequence

	sequence s_data_low;
		!reset_i && !demux_data_i;
	endsequence

	property p_select_xor;
		@(posedge core_clk_i) disable iff (reset_i)
		!$past(reset_i) |-> select_o == ($past(add_a_i) ^ $past(add_b_i));
	endproperty

	chk_select_from_xor: assert property (p_select_xor)
		else $error("adder select is not the operand xor");

	chk_demux_data_high: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		s_data_high |=> gate_enable_o && address_o == $past(demux_addr_i))
		else $error("demux data high not presented on enable");

	chk_demux_data_low: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		s_data_low |=> !gate_enable_o)
		else $error("demux data low not presented on enable");

	chk_cascade_from_init: assert property (
		@(posedge core_clk_i)
		!reset_i |=> reset_i or cascade_init_o)
		else $error("cascade init stage not driven high");

	chk_cascade_held_high: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		cascade_init_o |=> cascade_init_o [*2])
		else $error("cascade init dropped outside reset");

	chk_pattern_inverted: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		!$past(reset_i) |-> {decode_high_o, decode_low_o}
			== ($past(match_word_i) ^ ~$past(match_pattern_i)))
		else $error("zero-match bits not inverted");

	chk_pattern_exact_ones: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(!reset_i && match_word_i == match_pattern_i) |=> (&{decode_high_o, decode_low_o}))
		else $error("matching word does not give all ones");

	// launch edges: reset sampled low there, so the first edge out of reset is skipped
	sequence s_running;
		!reset_i;
	endsequence

	property p_follows_a;
		@(posedge core_clk_i) disable iff (reset_i)
		s_running |=> direct_in_o == $past(add_a_i);
	endproperty

	chk_direct_from_a: assert property (p_follows_a)
		else $error("direct input not operand a");

	chk_init_from_cin: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		s_running |=> init_direct_in_o == $past(add_cin_i))
		else $error("chain init not carry in");

	chk_address_follows: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		s_running |=> address_o == $past(demux_addr_i))
		else $error("decoder address not launched");

	// device results are captured unchanged; nothing is re-timed beyond one edge
	chk_carry_captured: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		s_running |=> carry_o == $past(chain_carry_out_i))
		else $error("chain carry not captured");

	chk_lines_captured: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		s_running |=> demux_capture_o == $past(demux_lines_i))
		else $error("decoder lines not captured");

	chk_hit_captured: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		s_running |=> match_o == $past(match_hit_i))
		else $error("match hit not captured");

	// reset must leave every launched and captured value low, cascade included;
	// match_o is cleared by its own reset, so no stale match shows during reset whatever the cascade
	chk_reset_adder_low: assert property (
		@(posedge core_clk_i)
		reset_i |=> direct_in_o == NIBBLE_RESET && select_o == NIBBLE_RESET
			&& !init_direct_in_o && !carry_o)
		else $error("adder outputs not cleared in reset");

	chk_reset_match_low: assert property (
		@(posedge core_clk_i)
		reset_i |=> !cascade_init_o && !match_o && !gate_enable_o
			&& demux_capture_o == LINE_RESET)
		else $error("matcher outputs not cleared in reset");

endmodule : decode_user_ctrl

// File: decode_user_pkg.sv
/*
 * constants, reset values and helper functions shared by the decoder user logic.
 * assumes the decoding elements outside are purely combinational.
 */
package decode_user_pkg;

	localparam int ADD_W   = 4;
	localparam int ADDR_W  = 4;
	localparam int LINE_N  = 16;
	localparam int MATCH_W = 16;
	localparam int HALF_W  = 8;

	localparam logic       CASCADE_INIT_ON  = 1'b1;
	localparam logic       BIT_RESET        = 1'b0;
	localparam logic [3:0] NIBBLE_RESET     = 4'h0;
	localparam logic [7:0] HALF_RESET       = 8'h00;
	localparam logic [15:0] LINE_RESET      = 16'h0000;

	// per-bit select of a carry-select stage in adder use
	function automatic logic [ADD_W-1:0] adder_select(
		input logic [ADD_W-1:0] opnd_a,
		input logic [ADD_W-1:0] opnd_b
	);
		adder_select = opnd_a ^ opnd_b;
	endfunction : adder_select

	// bits that must match zero are inverted, so an all-ones AND finds the pattern
	function automatic logic [MATCH_W-1:0] match_prep(
		input logic [MATCH_W-1:0] word,
		input logic [MATCH_W-1:0] pattern
	);
		match_prep = word ^ ~pattern;
	endfunction : match_prep

endpackage : decode_user_pkg

// File: encode_link_if.sv
/*
 * carrier between the top controller and its input encoder.
 * assumes both ends sit on the same clock; the encoder is combinational.
 */
`timescale 1ns/1ps
interface encode_link_if;
	import decode_user_pkg::*;

	logic [ADD_W-1:0]   opnd_a;
	logic [ADD_W-1:0]   opnd_b;
	logic [MATCH_W-1:0] word;
	logic [MATCH_W-1:0] pattern;
	logic [ADD_W-1:0]   select;
	logic [MATCH_W-1:0] decode_in;

	modport encoder (
		input  opnd_a,
		input  opnd_b,
		input  word,
		input  pattern,
		output select,
		output decode_in
	);

	modport ctrl (
		output opnd_a,
		output opnd_b,
		output word,
		output pattern,
		input  select,
		input  decode_in
	);

endinterface : encode_link_if

// File: input_encoder.sv
/*
 * combinational encoder: adder selects and pattern-prepared decode inputs.
 * assumes its results are registered by the controller before leaving the chip.
 */
`timescale 1ns/1ps
module input_encoder (
	encode_link_if.encoder link
);
	import decode_user_pkg::*;

	assign link.select    = adder_select(link.opnd_a, link.opnd_b);
	assign link.decode_in = match_prep(link.word, link.pattern);

endmodule : input_encoder

// File: decode_elements_model.sv
/* behavioural model of the decoding elements: carry chain, one-hot
   decoder and two cascaded wide AND stages.
   assumes registered drive from decode_user_ctrl; holds no state. */
`timescale 1ns/1ps
module decode_elements_model (
	input  wire logic [3:0]  direct_in_i,
	input  wire logic [3:0]  select_i,
	input  wire logic        init_i,
	input  wire logic        enable_i,
	input  wire logic [3:0]  address_i,
	input  wire logic [7:0]  low_i,
	input  wire logic [7:0]  high_i,
	input  wire logic        cascade_i,
	output logic             carry_o,
	output logic [15:0]      lines_o,
	output logic             hit_o,
	output logic             plain_o
);
	logic [4:0] chain;
	logic       stage1;
	logic       pull_down;

	// 2-to-4 is the building block; each wider decoder is a pair of the narrower
	function automatic logic [3:0] dec2(input logic en, input logic [1:0] a);
		dec2 = en ? (4'h1 << a) : 4'h0;
	endfunction : dec2

	function automatic logic [7:0] dec3(input logic en, input logic [2:0] a);
		dec3 = {dec2(en & a[2], a[1:0]), dec2(en & ~a[2], a[1:0])};
	endfunction : dec3

	assign chain[0] = init_i;
	for (genvar k = 0; k < 4; k++) begin : g_cy
		assign chain[k+1] = select_i[k] ? chain[k] : direct_in_i[k];
	end
	assign carry_o = chain[4];
	assign lines_o = {dec3(enable_i & address_i[3], address_i[2:0]),
		dec3(enable_i & ~address_i[3], address_i[2:0])};
	// open-drain form: the AND only ever pulls low, the pull-up supplies the high
	assign pull_down = ~&{high_i, low_i};
	assign plain_o   = pull_down ? 1'b0 : 1'b1;
	// a low stage output gates the next stage through its cascade input
	assign stage1 = (&low_i) & cascade_i;
	assign hit_o = (&high_i) & stage1;
endmodule : decode_elements_model

// File: line_decoders_and_carry_mux_bench.sv
/* self-checking bench for decode_user_ctrl with the element model.
   assumes two cycles from input to captured device result. */
`timescale 1ns/1ps
module line_decoders_and_carry_mux_bench;
	logic        core_clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [3:0]  a = 4'h0, b = 4'h0, da = 4'h0, di, sel, ad;
	logic        cin = 1'b0, dd = 1'b0, ini, en, ci, co, hit, carry, mt, pl;
	logic [15:0] w = 16'h0000, p = 16'h0000, ln, cap;
	logic [7:0]  lo, hi;
	int          n_fail = 0, comparisons = 0, cycles = 0;

	initial forever #10 core_clk_i = ~core_clk_i;

	decode_user_ctrl u_decode_user_ctrl (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.add_a_i(a), .add_b_i(b), .add_cin_i(cin), .demux_data_i(dd), .demux_addr_i(da),
		.match_word_i(w), .match_pattern_i(p), .chain_carry_out_i(co), .demux_lines_i(ln),
		.match_hit_i(hit), .direct_in_o(di), .select_o(sel), .init_direct_in_o(ini),
		.gate_enable_o(en), .address_o(ad), .decode_low_o(lo), .decode_high_o(hi),
		.cascade_init_o(ci), .carry_o(carry), .demux_capture_o(cap), .match_o(mt));

	decode_elements_model u_decode_elements_model (.direct_in_i(di), .select_i(sel),
		.init_i(ini), .enable_i(en), .address_i(ad), .low_i(lo), .high_i(hi),
		.cascade_i(ci), .carry_o(co), .lines_o(ln), .hit_o(hit), .plain_o(pl));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	// result is captured two edges after the drive edge; one spare edge
	task automatic settle();
		repeat (3) @(posedge core_clk_i);
		#1;
	endtask : settle

	task automatic t_adder();
		logic [4:0] sum;
		for (int i = 0; i < 16; i++) begin
			@(posedge core_clk_i);
			a <= 4'(i);
			b <= 4'(i * 5 + 3);
			cin <= i[0];
			settle();
			sum = {1'b0, a} + {1'b0, b} + {4'h0, cin};
			chk(16'(sel), 16'(a ^ b));
			chk(16'(carry), 16'(sum[4]));
			chk(16'(di), 16'(a));
			chk(16'(ini), 16'(cin));
		end
	endtask : t_adder

	task automatic t_demux();
		for (int i = 0; i < 32; i++) begin
			@(posedge core_clk_i);
			da <= 4'(i);
			dd <= (i < 16);
			settle();
			chk(cap, (i < 16) ? (16'h0001 << i[3:0]) : 16'h0000);
			chk(16'(en), 16'(dd));
			chk(16'(ad), 16'(da));
		end
	endtask : t_demux

	task automatic t_match();
		logic [15:0] flip[3] = '{16'h0000, 16'h0010, 16'h0200};
		for (int i = 0; i < 3; i++) begin
			@(posedge core_clk_i);
			p <= 16'hA5C3;
			w <= 16'hA5C3 ^ flip[i];
			settle();
			chk(16'(mt), (i == 0) ? 16'h0001 : 16'h0000);
			chk(16'(pl), (i == 0) ? 16'h0001 : 16'h0000);
			chk({hi, lo}, ~flip[i]);
			chk(16'(ci), 16'h0001);
		end
	endtask : t_match

	task automatic t_reset();
		@(posedge core_clk_i);
		w <= p;
		reset_i <= 1'b1;
		settle();
		chk(16'(mt), 16'h0000);
		chk(16'(ci), 16'h0000);
		@(posedge core_clk_i);
		reset_i <= 1'b0;
		settle();
		chk(16'(mt), 16'h0001);
	endtask : t_reset

	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 1000) begin
			n_fail++;
			conclude();
		end
	end

	initial begin
		repeat (10) @(posedge core_clk_i);
		reset_i <= 1'b0;
		t_adder();
		t_demux();
		t_match();
		t_reset();
		conclude();
	end
endmodule : line_decoders_and_carry_mux_bench
